// ### rtl/biop_pkg.sv
// Constants, register map and shared types of the bidirectional port block
package biop_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int PA_W = 5;
	localparam int PB_W = 8;
	localparam int ANALOG_W = 4;
	localparam int IDX_W = 8;
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------
	// Register indices; byte address is four times the index
	// ----------------------------------------
	localparam logic [IDX_W-1:0] IDX_PA_DATA = 8'h05;
	localparam logic [IDX_W-1:0] IDX_PB_DATA = 8'h06;
	localparam logic [IDX_W-1:0] IDX_PA_SET = 8'h10;
	localparam logic [IDX_W-1:0] IDX_PA_CLR = 8'h11;
	localparam logic [IDX_W-1:0] IDX_PB_SET = 8'h12;
	localparam logic [IDX_W-1:0] IDX_PB_CLR = 8'h13;
	localparam logic [IDX_W-1:0] IDX_OPTION = 8'h81;
	localparam logic [IDX_W-1:0] IDX_PA_DIR = 8'h85;
	localparam logic [IDX_W-1:0] IDX_PB_DIR = 8'h86;
	localparam logic [IDX_W-1:0] IDX_ANALOG = 8'h9f;

	// Bit positions of the index inside an APB address
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = IDX_LSB + IDX_W - 1;

	// ----------------------------------------
	// Reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] RST_OPTION = 8'hff;
	localparam logic [PB_W-1:0] RST_PB_DIR = 8'hff;
	localparam logic [PA_W-1:0] RST_PA_DIR = 5'h1f;
	localparam logic [ANALOG_W-1:0] RST_ANALOG = 4'hf;
	localparam logic [PB_W-1:0] RST_PB_LATCH = 8'h00;
	localparam logic [PA_W-1:0] RST_PA_LATCH = 5'h00;
	localparam int OPT_PULLUP_BIT = 7;
	localparam int PA_TIMER_BIT = 4;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	// Latch and direction of one port travel together
	typedef struct packed {
		logic [PB_W-1:0] latch;
		logic [PB_W-1:0] dir;
	} biop_port_s;

	// Modification applied on a data write: store pwdata, or set or clear the sampled pins
	typedef enum logic [1:0] {WOP_NONE, WOP_STORE, WOP_SET, WOP_CLR} biop_wop_e;

	// APB slave phase
	typedef enum logic {APB_IDLE, APB_ACCESS} biop_apb_e;

endpackage : biop_pkg

// ### rtl/biop_sync.sv
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps

module biop_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end

endmodule : biop_sync

// ### rtl/biop_ports.sv
// Two bidirectional I/O ports behind an APB register slave
// Function
// - Port A has five pins, each with one latch bit and one direction bit.
// - Port A direction bit 1 puts that pin driver in high impedance.
// - Port A direction bit 0 drives the pin from its latch bit.
// - Data register reads return pin levels; writes update only the latch.
// - Set and clear writes sample pins, modify, then store into the latch; plain data writes store pwdata.
// - Self-referencing modifications take pin levels, so low inputs write zero.
// - Port A bit 4 feeds the timer clock and drives open drain only.
// - Port A bits 3:0 select digital or analog by analog config bits.
// - After reset bits 3:0 are analog and digital reads return zero.
// - Direction bits still steer drivers in analog use; software keeps them set.
// - Port B has eight pins with direction: 1 input, 0 drives latch.
// - Port B weak pull-ups enabled together by clearing option bit 7.
// - A port B pull-up is off whenever that pin is an output.
// - Port B pull-ups are disabled after reset.
// - Port B direction resets to all ones on every reset.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

module biop_ports #(
	parameter int PA_W = biop_pkg::PA_W,
	parameter int PB_W = biop_pkg::PB_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [biop_pkg::ADDR_W-1:0] paddr,
	input wire logic [biop_pkg::DATA_W-1:0] pwdata,
	output logic [biop_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PA_W-1:0] paIn,
	output logic [PA_W-1:0] paOut,
	output logic [PA_W-1:0] paOeN,
	input wire logic [PB_W-1:0] pbIn,
	output logic [PB_W-1:0] pbOut,
	output logic [PB_W-1:0] pbOeN,
	output logic [PB_W-1:0] pbPullupEn,
	output logic timerClockInput,
	output logic [biop_pkg::ANALOG_W-1:0] analogSelect
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam int AW = biop_pkg::ANALOG_W;
	localparam int TB = biop_pkg::PA_TIMER_BIT;
	// Timer pin position as a port-wide mask, sized to the port
	localparam logic [PA_W-1:0] OD_MASK = PA_W'(1) << TB;

	biop_pkg::biop_apb_e state_q;
	biop_pkg::biop_port_s port_a_data_q;
	biop_pkg::biop_port_s port_b_data_q;
	logic [7:0] option_q;
	logic [AW-1:0] analog_q;
	logic [PA_W-1:0] paSync;
	logic [PB_W-1:0] pbSync;
	logic [PA_W-1:0] paRead;
	logic [biop_pkg::IDX_W-1:0] idx;
	logic hit;
	logic [biop_pkg::DATA_W-1:0] rdData;
	logic wrEn;
	biop_pkg::biop_wop_e opA;
	biop_pkg::biop_wop_e opB;
	logic [PA_W-1:0] wrA;
	logic [PB_W-1:0] wrB;
	logic [PA_W-1:0] latchA;
	logic [PA_W-1:0] dirA;

	// ----------------------------------------
	// Pin sampling
	// ----------------------------------------
	// Both ports are read through two-flop synchronisers
	biop_sync #(.W(PA_W)) u_sync_a (
		.clk(clk),
		.rstn(rstn),
		.din(paIn),
		.dout(paSync)
	);

	biop_sync #(.W(PB_W)) u_sync_b (
		.clk(clk),
		.rstn(rstn),
		.din(pbIn),
		.dout(pbSync)
	);

	// Analog pins read as zero on the digital side
	assign paRead = paSync & ~{{(PA_W-AW){1'b0}}, analog_q};
	assign latchA = port_a_data_q.latch[PA_W-1:0];
	assign dirA = port_a_data_q.dir[PA_W-1:0];

	// ----------------------------------------
	// APB decode and read mux
	// ----------------------------------------
	assign idx = paddr[biop_pkg::IDX_MSB:biop_pkg::IDX_LSB];

	// Address decode; unmapped words read zero and flag an error
	always_comb begin
		hit = 1'b1;
		rdData = '0;
		case (idx)
			biop_pkg::IDX_PA_DATA: rdData[PA_W-1:0] = paRead;
			biop_pkg::IDX_PB_DATA: rdData[PB_W-1:0] = pbSync;
			biop_pkg::IDX_PA_DIR: rdData[PA_W-1:0] = dirA;
			biop_pkg::IDX_PB_DIR: rdData[PB_W-1:0] = port_b_data_q.dir;
			biop_pkg::IDX_OPTION: rdData[7:0] = option_q;
			biop_pkg::IDX_ANALOG: rdData[AW-1:0] = analog_q;
			biop_pkg::IDX_PA_SET, biop_pkg::IDX_PA_CLR: rdData[PA_W-1:0] = paRead;
			biop_pkg::IDX_PB_SET, biop_pkg::IDX_PB_CLR: rdData[PB_W-1:0] = pbSync;
			default: hit = 1'b0;
		endcase
		if (paddr[biop_pkg::IDX_LSB-1:0] != '0 || paddr[biop_pkg::ADDR_W-1:biop_pkg::IDX_MSB+1] != '0) begin
			hit = 1'b0;
			rdData = '0;
		end
	end

	// ----------------------------------------
	// APB phase tracking and answer
	// ----------------------------------------
	// Answer without wait states: pready rises for the access cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= biop_pkg::APB_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			case (state_q)
				biop_pkg::APB_IDLE: begin
					if (psel && !penable) begin
						state_q <= biop_pkg::APB_ACCESS;
						pready <= 1'b1;
						pslverr <= !hit;
						prdata <= pwrite ? '0 : rdData;
					end
				end
				biop_pkg::APB_ACCESS: begin
					state_q <= biop_pkg::APB_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
				default: begin
					state_q <= biop_pkg::APB_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
			endcase
		end
	end

	// Write takes effect only at the completing access edge
	assign wrEn = psel && penable && pwrite && pready && !pslverr;

	// ----------------------------------------
	// Read-modify-write of the output latches
	// ----------------------------------------
	// Pick the modification applied to each port
	always_comb begin
		opA = biop_pkg::WOP_NONE;
		opB = biop_pkg::WOP_NONE;
		if (wrEn) begin
			case (idx)
				biop_pkg::IDX_PA_DATA: opA = biop_pkg::WOP_STORE;
				biop_pkg::IDX_PA_SET: opA = biop_pkg::WOP_SET;
				biop_pkg::IDX_PA_CLR: opA = biop_pkg::WOP_CLR;
				biop_pkg::IDX_PB_DATA: opB = biop_pkg::WOP_STORE;
				biop_pkg::IDX_PB_SET: opB = biop_pkg::WOP_SET;
				biop_pkg::IDX_PB_CLR: opB = biop_pkg::WOP_CLR;
				default: begin
					opA = biop_pkg::WOP_NONE;
					opB = biop_pkg::WOP_NONE;
				end
			endcase
		end
	end

	// Port A: sampled pins are the source of set and clear; a store takes pwdata
	always_comb begin
		case (opA)
			biop_pkg::WOP_STORE: wrA = pwdata[PA_W-1:0];
			biop_pkg::WOP_SET: wrA = paRead | pwdata[PA_W-1:0];
			biop_pkg::WOP_CLR: wrA = paRead & ~pwdata[PA_W-1:0];
			default: wrA = latchA;
		endcase
	end

	// Port B: same scheme
	always_comb begin
		case (opB)
			biop_pkg::WOP_STORE: wrB = pwdata[PB_W-1:0];
			biop_pkg::WOP_SET: wrB = pbSync | pwdata[PB_W-1:0];
			biop_pkg::WOP_CLR: wrB = pbSync & ~pwdata[PB_W-1:0];
			default: wrB = port_b_data_q.latch;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Port A latch and direction
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			port_a_data_q.latch <= '0;
			port_a_data_q.dir <= {{(PB_W-PA_W){1'b0}}, biop_pkg::RST_PA_DIR};
		end else begin
			port_a_data_q.latch[PA_W-1:0] <= wrA;
			if (wrEn && idx == biop_pkg::IDX_PA_DIR) begin
				port_a_data_q.dir[PA_W-1:0] <= pwdata[PA_W-1:0];
			end
		end
	end

	// Port B latch and direction
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			port_b_data_q.latch <= biop_pkg::RST_PB_LATCH;
			port_b_data_q.dir <= biop_pkg::RST_PB_DIR;
		end else begin
			port_b_data_q.latch <= wrB;
			if (wrEn && idx == biop_pkg::IDX_PB_DIR) begin
				port_b_data_q.dir <= pwdata[PB_W-1:0];
			end
		end
	end

	// Option and analog configuration
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			option_q <= biop_pkg::RST_OPTION;
			analog_q <= biop_pkg::RST_ANALOG;
		end else begin
			if (wrEn && idx == biop_pkg::IDX_OPTION) begin
				option_q <= pwdata[7:0];
			end
			if (wrEn && idx == biop_pkg::IDX_ANALOG) begin
				analog_q <= pwdata[AW-1:0];
			end
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// Port A: push-pull on low bits, open drain on the timer pin
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			paOut <= '0;
			paOeN <= '1;
		end else begin
			paOut <= latchA & ~OD_MASK;
			paOeN <= dirA;
			paOeN[TB] <= dirA[TB] | latchA[TB];
		end
	end

	// Port B drivers and weak pull-ups
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pbOut <= '0;
			pbOeN <= '1;
			pbPullupEn <= '0;
		end else begin
			pbOut <= port_b_data_q.latch;
			pbOeN <= port_b_data_q.dir;
			pbPullupEn <= {PB_W{!option_q[biop_pkg::OPT_PULLUP_BIT]}} & port_b_data_q.dir;
		end
	end

	// Timer clock tap and analog select outputs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			timerClockInput <= 1'b0;
			analogSelect <= biop_pkg::RST_ANALOG;
		end else begin
			timerClockInput <= paSync[TB];
			analogSelect <= analog_q;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_pa_input_hiz: assert property (&dirA |=> paOeN == '1)
		else $error("port A input pin driven");

	a_pa_output_drive: assert property (dirA[0] == 1'b0 |=> !paOeN[0] && paOut[0] == $past(latchA[0]))
		else $error("port A output does not follow latch");

	a_rmw_clear_src: assert property (opA == biop_pkg::WOP_CLR |=> latchA == $past(paRead & ~pwdata[PA_W-1:0]))
		else $error("clear did not use pin levels");

	a_read_pins: assert property (psel && !penable && !pwrite && idx == biop_pkg::IDX_PB_DATA && state_q == biop_pkg::APB_IDLE
		&& hit |=> prdata[PB_W-1:0] == $past(pbSync))
		else $error("port B read is not pin level");

	a_timer_open_drain: assert property (!paOeN[TB] |-> paOut[TB] == 1'b0)
		else $error("timer pin drives high");

	a_analog_reads_zero: assert property (analog_q[0] |-> paRead[0] == 1'b0)
		else $error("analog pin read non-zero");

	a_pullup_out_off: assert property (!port_b_data_q.dir[0] |=> !pbPullupEn[0])
		else $error("pull-up on while output");

	a_pullup_global: assert property (option_q[biop_pkg::OPT_PULLUP_BIT] |=> pbPullupEn == '0)
		else $error("pull-up on while disabled");

	a_pin_sync_delay: assert property (##2 pbOut == $past(port_b_data_q.latch) && timerClockInput == $past(paSync[TB]))
		else $error("pin path latency wrong");

	a_apb_ready: assert property (psel && !penable && state_q == biop_pkg::APB_IDLE |=> pready ##1 !pready)
		else $error("pready not one cycle");

	c_rmw_set: cover property (opB == biop_pkg::WOP_SET);
	c_unmapped: cover property (pready && pslverr);
	c_analog_off: cover property (analog_q == '0 ##1 paRead != '0);
	c_pullup_on: cover property (pbPullupEn != '0);

endmodule : biop_ports

// ### verification/biop_pin_model.sv
// Model of the outside circuitry that sits on the port pins
`timescale 1ns/1ps

module biop_pin_model (
	input wire logic clk,
	input wire logic [biop_pkg::PA_W-1:0] paOut,
	input wire logic [biop_pkg::PA_W-1:0] paOeN,
	input wire logic [biop_pkg::PB_W-1:0] pbOut,
	input wire logic [biop_pkg::PB_W-1:0] pbOeN,
	input wire logic [biop_pkg::PB_W-1:0] pbPullupEn,
	input wire logic [biop_pkg::PA_W-1:0] paExt,
	input wire logic [biop_pkg::PA_W-1:0] paExtEn,
	input wire logic [biop_pkg::PB_W-1:0] pbExt,
	input wire logic [biop_pkg::PB_W-1:0] pbExtEn,
	output logic [biop_pkg::PA_W-1:0] paIn,
	output logic [biop_pkg::PB_W-1:0] pbIn
);
	logic flt;
	// Undriven lines wander so a stale level never passes for a real one
	initial flt = 1'b0;
	always @(posedge clk) flt <= ~flt;
	// Device driver wins, then the outside driver, then the port B pull-up
	always_comb begin
		for (int i = 0; i < biop_pkg::PA_W; i++) begin
			paIn[i] = !paOeN[i] ? paOut[i] : paExtEn[i] ? paExt[i] : flt;
		end
		for (int i = 0; i < biop_pkg::PB_W; i++) begin
			pbIn[i] = !pbOeN[i] ? pbOut[i] : pbExtEn[i] ? pbExt[i] : pbPullupEn[i] ? 1'b1 : flt;
		end
	end
endmodule : biop_pin_model

// ### verification/biop_ports_tb_top.sv
// Self-checking bench for the two bidirectional ports
`timescale 1ns/1ps

module biop_ports_tb_top;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, timerClockInput;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [4:0] paIn, paOut, paOeN, paExt, paExtEn;
	logic [7:0] pbIn, pbOut, pbOeN, pbPullupEn, pbExt, pbExtEn;
	logic [3:0] analogSelect;
	logic errv;
	int n_fail, cmp_count;

	biop_ports u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.paIn(paIn), .paOut(paOut), .paOeN(paOeN), .pbIn(pbIn), .pbOut(pbOut), .pbOeN(pbOeN),
		.pbPullupEn(pbPullupEn), .timerClockInput(timerClockInput), .analogSelect(analogSelect));
	biop_pin_model u_pins (.clk(clk), .paOut(paOut), .paOeN(paOeN), .pbOut(pbOut), .pbOeN(pbOeN),
		.pbPullupEn(pbPullupEn), .paExt(paExt), .paExtEn(paExtEn), .pbExt(pbExt), .pbExtEn(pbExtEn),
		.paIn(paIn), .pbIn(pbIn));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One APB transfer; setup, then access until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_fail++;
			conclude();
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
		xfer(1'b0, idx, 32'h0);
		chk(nm, e, rdv);
	endtask : rdchk

	// Let outputs, pins and the pin synchroniser settle
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask : settle

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_reset();
		chk("pullups", 8'h00, pbPullupEn);
		chk("pbOeN", 8'hff, pbOeN);
		chk("paOeN", 5'h1f, paOeN);
		chk("analog", 4'hf, analogSelect);
		rdchk("option", biop_pkg::IDX_OPTION, 32'hff);
		chk("okErr", 1'b0, errv);
		rdchk("pbDir", biop_pkg::IDX_PB_DIR, 32'hff);
		rdchk("paDir", biop_pkg::IDX_PA_DIR, 32'h1f);
		rdchk("anaCfg", biop_pkg::IDX_ANALOG, 32'hf);
		rdchk("paAnalog", biop_pkg::IDX_PA_DATA, 32'h10);
		rdchk("unmapped", 8'h40, 32'h0);
		chk("slverr", 1'b1, errv);
		xfer(1'b1, 8'h40, 32'hff);
		chk("wrErr", 1'b1, errv);
	endtask : s_reset

	task automatic s_port_b_data();
		xfer(1'b1, biop_pkg::IDX_PB_DATA, 32'ha5);
		xfer(1'b1, biop_pkg::IDX_PB_DIR, 32'h0f);
		settle();
		chk("pbOeN", 8'h0f, pbOeN);
		chk("pbOut", 8'ha5, pbOut);
		rdchk("pbPins", biop_pkg::IDX_PB_DATA, 32'ha3);
		xfer(1'b1, biop_pkg::IDX_OPTION, 32'h7f);
		settle();
		chk("pullups", 8'h0f, pbPullupEn);
		@(posedge clk);
		pbExtEn <= 8'h00;
		settle();
		rdchk("pulled", biop_pkg::IDX_PB_DATA, 32'haf);
		xfer(1'b1, biop_pkg::IDX_OPTION, 32'hff);
		settle();
		chk("pullOff", 8'h00, pbPullupEn);
	endtask : s_port_b_data

	// Modify writes take pins, so latch bits of low inputs come back as zero
	task automatic s_rmw();
		@(posedge clk);
		pbExtEn <= 8'h0f;
		pbExt <= 8'h00;
		xfer(1'b1, biop_pkg::IDX_PB_SET, 32'h40);
		settle();
		chk("setOut", 8'he0, pbOut);
		xfer(1'b1, biop_pkg::IDX_PB_CLR, 32'h80);
		settle();
		chk("clrOut", 8'h60, pbOut);
	endtask : s_rmw

	task automatic s_port_a_data();
		@(posedge clk);
		paExt <= 5'h1f;
		paExtEn <= 5'h10;
		xfer(1'b1, biop_pkg::IDX_ANALOG, 32'h0);
		xfer(1'b1, biop_pkg::IDX_PA_DIR, 32'h0);
		xfer(1'b1, biop_pkg::IDX_PA_DATA, 32'h1f);
		settle();
		chk("paOut", 5'h0f, paOut);
		chk("paOeN", 5'h10, paOeN);
		chk("timer", 1'b1, timerClockInput);
		rdchk("paPins", biop_pkg::IDX_PA_DATA, 32'h1f);
		xfer(1'b1, biop_pkg::IDX_PA_DATA, 32'h0f);
		settle();
		chk("paOeN0", 5'h00, paOeN);
		chk("timer0", 1'b0, timerClockInput);
		xfer(1'b1, biop_pkg::IDX_PA_CLR, 32'h01);
		settle();
		chk("paClr", 5'h0e, paOut);
		xfer(1'b1, biop_pkg::IDX_PA_SET, 32'h10);
		settle();
		chk("paSetOeN", 5'h10, paOeN);
		xfer(1'b1, biop_pkg::IDX_PA_CLR, 32'h10);
		settle();
		chk("paClrOeN", 5'h00, paOeN);
		xfer(1'b1, biop_pkg::IDX_ANALOG, 32'hf);
		settle();
		chk("anaOeN", 5'h00, paOeN);
		chk("anaSel", 4'hf, analogSelect);
		rdchk("anaRead", biop_pkg::IDX_PA_DATA, 32'h0);
		// Software keeps analog pins as inputs
		xfer(1'b1, biop_pkg::IDX_PA_DIR, 32'h1f);
		settle();
		chk("anaDirSet", 5'h1f, paOeN);
	endtask : s_port_a_data

	// A reset in mid-run brings directions and pull-ups back to their start values
	task automatic s_midreset();
		xfer(1'b1, biop_pkg::IDX_PB_DIR, 32'hf0);
		xfer(1'b1, biop_pkg::IDX_OPTION, 32'h00);
		settle();
		chk("prePull", 8'hf0, pbPullupEn);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		settle();
		chk("rstOeN", 8'hff, pbOeN);
		chk("rstPull", 8'h00, pbPullupEn);
		chk("rstOut", 8'h00, pbOut);
		rdchk("rstDir", biop_pkg::IDX_PB_DIR, 32'hff);
	endtask : s_midreset

	// ----------------------------------------
	// Clock, run and verdict
	// ----------------------------------------
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Watchdog well beyond the run length
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		conclude();
	end

	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata} = '0;
		{paExt, paExtEn, pbExt} = {5'h1f, 5'h1f, 8'h03};
		pbExtEn = 8'h0f;
		n_fail = 0;
		cmp_count = 0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		settle();
		s_reset();
		s_port_b_data();
		s_rmw();
		s_port_a_data();
		s_midreset();
		conclude();
	end
endmodule : biop_ports_tb_top
